// file: hdl/pin_mux_pkg.sv
// Constants, field layouts and helpers for the port B pin function select
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // Pin and function geometry
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 10;
  localparam int CODE_W = 2;
  localparam int SLOT_COUNT = 4;
  localparam int IRQ_COUNT = 8;
  localparam int POE_COUNT = 4;
  localparam int IRQ_FIRST_PIN = 2;
  localparam int POE_FIRST_PIN = 2;
  localparam int UPPER_FIRST_PIN = 8;
  localparam int PIN1 = 1;
  localparam int PIN0 = 0;
  localparam int ADC_PIN = 9;
  localparam int WAIT_PIN = 8;
  localparam int BUS_REQUEST_IN_N_PIN = 7;

  // Selection codes as written by software
  localparam logic [CODE_W-1:0] CODE_GPIO = 2'h0;
  localparam logic [CODE_W-1:0] CODE_ALT1 = 2'h1;
  localparam logic [CODE_W-1:0] CODE_ALT2 = 2'h2;
  localparam logic [CODE_W-1:0] CODE_ALT3 = 2'h3;

  // Effective function, one-hot
  localparam logic [SLOT_COUNT-1:0] SLOT_GPIO = 4'h1;
  localparam logic [SLOT_COUNT-1:0] SLOT_ALT1 = 4'h2;
  localparam logic [SLOT_COUNT-1:0] SLOT_ALT2 = 4'h4;
  localparam logic [SLOT_COUNT-1:0] SLOT_ALT3 = 4'h8;
  localparam int SLOT_IDX_GPIO = 0;
  localparam int SLOT_IDX_ALT1 = 1;
  localparam int SLOT_IDX_ALT2 = 2;
  localparam int SLOT_IDX_ALT3 = 3;

  // ----------------------------------------------------------------
  // Per-pin mode behaviour masks, bit n is pin n
  // ----------------------------------------------------------------
  localparam logic [PIN_COUNT-1:0] DROP2_MASK = 10'h3C3; // Code 2 to GPIO
  localparam logic [PIN_COUNT-1:0] DROP3_MASK = 10'h1DC; // Code 3 to GPIO
  localparam logic [PIN_COUNT-1:0] ROM_FORCE_MASK = 10'h003;
  localparam logic [PIN_COUNT-1:0] ALT2_DRIVE = 10'h3C3; // Address outs
  localparam logic [PIN_COUNT-1:0] ALT3_DRIVE = 10'h07C; // Bus strobes

  // ----------------------------------------------------------------
  // Register map, byte addresses on the Avalon slave
  // ----------------------------------------------------------------
  localparam int AVS_ADDR_W = 4;
  localparam int AVS_DATA_W = 32;
  localparam int AVS_BE_W = 4;
  localparam int WORD_SEL_LSB = 2;
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [AVS_ADDR_W-1:0] UPPER_OFFSET = 4'h0;
  localparam logic [AVS_ADDR_W-1:0] LOWER_OFFSET = 4'h4;
  localparam logic [AVS_ADDR_W-1:0] LEVEL_OFFSET = 4'h8;
  localparam logic [REG_W-1:0] UPPER_RESET = 16'h0000;
  localparam logic [REG_W-1:0] LOWER_RESET = 16'h0000;
  localparam logic [REG_W-1:0] UPPER_WMASK = 16'h000F;
  localparam logic [REG_W-1:0] LOWER_WMASK = 16'hFFF5;
  localparam int PIN1_SEL_BIT = 2;
  localparam int PIN0_SEL_BIT = 0;
  localparam int LEVEL_SC_BIT = 16;
  localparam int LEVEL_ROM_BIT = 17;

  // Word decode on byte address
  function automatic logic reg_hit(input logic [AVS_ADDR_W-1:0] addr,
                                   input logic [AVS_ADDR_W-1:0] off);
    reg_hit = addr[AVS_ADDR_W-1:WORD_SEL_LSB] ==
              off[AVS_ADDR_W-1:WORD_SEL_LSB];
  endfunction : reg_hit

  // Byte-lane write merge with reserved bits forced to zero
  function automatic logic [REG_W-1:0] merge_write(
      input logic [REG_W-1:0] old,
      input logic [REG_W-1:0] wdata,
      input logic [AVS_BE_W-1:0] be,
      input logic [REG_W-1:0] wmask);
    logic [REG_W-1:0] lanes;
    lanes = {{BYTE_W{be[1]}}, {BYTE_W{be[0]}}};
    merge_write = ((old & ~lanes) | (wdata & lanes)) & wmask;
  endfunction : merge_write

endpackage : pin_mux_pkg

// file: hdl/pin_select_decode.sv
// Decodes one pin's selection code into its effective one-hot function
`timescale 1ns/100ps
module pin_select_decode
  import pin_mux_pkg::*;
#(
  parameter bit DROP2 = 1'b0,
  parameter bit DROP3 = 1'b0,
  parameter bit ROM_FORCE = 1'b0
) (
  // Programmed code
  input wire logic [CODE_W-1:0] code,
  // Operating mode
  input wire logic single_chip_mode,
  input wire logic rom_invalid_mode,
  // Effective function
  output logic [SLOT_COUNT-1:0] slot
);

  // Mode override of the programmed code
  always_comb begin
    slot = SLOT_GPIO;
    unique case (code)
      CODE_GPIO: begin
        slot = (ROM_FORCE && rom_invalid_mode && !single_chip_mode) ?
               SLOT_ALT2 : SLOT_GPIO;
      end
      CODE_ALT1: begin
        slot = SLOT_ALT1;
      end
      CODE_ALT2: begin
        slot = (DROP2 && single_chip_mode) ? SLOT_GPIO : SLOT_ALT2;
      end
      CODE_ALT3: begin
        slot = (DROP3 && single_chip_mode) ? SLOT_GPIO : SLOT_ALT3;
      end
    endcase
  end

endmodule : pin_select_decode

// file: hdl/port_b_pin_function_select.sv
// Port B pin function select: registers, mode override and pin routing
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps

module port_b_pin_function_select
  import pin_mux_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM register slave
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [AVS_DATA_W-1:0] avs_writedata,
  input wire logic [AVS_BE_W-1:0] avs_byteenable,
  output logic [AVS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Operating mode
  input wire logic single_chip_mode,
  input wire logic rom_invalid_mode,
  // Port pins
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  // General I/O side
  input wire logic [PIN_COUNT-1:0] port_b_direction_register,
  input wire logic [PIN_COUNT-1:0] gpio_out,
  output logic [PIN_COUNT-1:0] gpio_in,
  // Interrupt controller side
  output logic [IRQ_COUNT-1:0] interrupt_request_in,
  // Timer output enable side
  output logic [POE_COUNT-1:0] output_enable_in,
  // A/D converter side
  output logic adc_trigger_in,
  // Bus controller side
  input wire logic address_bit_21,
  input wire logic address_bit_20,
  input wire logic address_bit_19,
  input wire logic address_bit_18,
  input wire logic address_bit_17,
  input wire logic address_bit_16,
  input wire logic read_write_direction_out,
  input wire logic upper_column_strobe,
  input wire logic lower_column_strobe,
  input wire logic row_address_strobe,
  input wire logic bus_grant_out,
  output logic bus_wait_in,
  output logic bus_request_in_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  typedef struct packed {
    logic [REG_W-1:0] upper;
    logic [REG_W-1:0] lower;
    logic ack;
    logic [AVS_DATA_W-1:0] rdata;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic [PIN_COUNT-1:0] gpio_in;
    logic [IRQ_COUNT-1:0] irq;
    logic [POE_COUNT-1:0] poe;
    logic adc;
    logic wait_in;
    logic bus_request_in_n_n;
  } state_t;

  // Bus request idles high so the arbiter sees no request
  localparam state_t STATE_RESET = '{
    upper: UPPER_RESET,
    lower: LOWER_RESET,
    bus_request_in_n_n: 1'b1,
    default: '0
  };

  state_t state_q;
  state_t state_d;

  logic req;
  logic [AVS_DATA_W-1:0] read_mux;
  logic [PIN_COUNT-1:0] alt2_val;
  logic [PIN_COUNT-1:0] alt3_val;
  logic [CODE_W-1:0] code [PIN_COUNT];
  logic [SLOT_COUNT-1:0] slot [PIN_COUNT];
  logic hit_upper;
  logic hit_lower;
  logic hit_level;
  logic write_land;
  logic [PIN_COUNT-1:0] drive_oe;
  logic [PIN_COUNT-1:0] drive_val;
  logic [IRQ_COUNT-1:0] irq_sel;
  logic [POE_COUNT-1:0] poe_sel;
  logic adc_sel;
  logic wait_sel;
  logic bus_request_in_n_sel;

  // ----------------------------------------------------------------
  // Function map per pin, code 0 to 3
  // ----------------------------------------------------------------

  // Pin 9: GPIO, irq 7, address 21, ADC trigger in
  // Pin 8: GPIO, irq 6, address 20, wait request in
  // Pin 7: GPIO, irq 5, address 19, bus request in
  // Pin 6: GPIO, irq 4, address 18, bus grant out
  // Pin 5: GPIO, irq 3, output enable 3, read/write out
  // Pin 4: GPIO, irq 2, output enable 2, upper column strobe
  // Pin 3: GPIO, irq 1, output enable 1, lower column strobe
  // Pin 2: GPIO, irq 0, output enable 0, row strobe
  // Pins 1 and 0: GPIO or address 17 and 16
  // Single chip mode turns bus and address codes into GPIO,
  // except the read/write strobe and the ADC trigger
  // ROM-invalid mode puts address on pins 1 and 0 with code 0

  // ----------------------------------------------------------------
  // Selection code extraction
  // ----------------------------------------------------------------

  // Two-bit codes for pins 2-9, single-bit codes for pins 0 and 1
  function automatic logic [CODE_W-1:0] pin_code(
      input logic [REG_W-1:0] upper,
      input logic [REG_W-1:0] lower,
      input int idx);
    pin_code = CODE_GPIO;
    if (idx >= UPPER_FIRST_PIN) begin
      pin_code = upper[CODE_W*(idx-UPPER_FIRST_PIN) +: CODE_W];
    end else if (idx >= IRQ_FIRST_PIN) begin
      pin_code = lower[CODE_W*idx +: CODE_W];
    end else if (idx == PIN1) begin
      pin_code = lower[PIN1_SEL_BIT] ? CODE_ALT2 : CODE_GPIO;
    end else begin
      pin_code = lower[PIN0_SEL_BIT] ? CODE_ALT2 : CODE_GPIO;
    end
  endfunction : pin_code

  // One decoder per pin, mode behaviour set from the pin masks
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign code[i] = pin_code(state_q.upper, state_q.lower, i);

    pin_select_decode #(
      .DROP2(DROP2_MASK[i]),
      .DROP3(DROP3_MASK[i]),
      .ROM_FORCE(ROM_FORCE_MASK[i])
    ) u_decode (
      .code(code[i]),
      .single_chip_mode(single_chip_mode),
      .rom_invalid_mode(rom_invalid_mode),
      .slot(slot[i])
    );
  end

  // ----------------------------------------------------------------
  // Peripheral outputs placed on pins
  // ----------------------------------------------------------------

  // Address outputs on code 2, pins 9-6 and 1-0
  assign alt2_val = {
    address_bit_21,
    address_bit_20,
    address_bit_19,
    address_bit_18,
    4'h0,
    address_bit_17,
    address_bit_16
  };

  // Bus strobes on code 3, pins 6-2
  assign alt3_val = {
    3'h0,
    bus_grant_out,
    read_write_direction_out,
    upper_column_strobe,
    lower_column_strobe,
    row_address_strobe,
    2'h0
  };

  // ----------------------------------------------------------------
  // Pin drive and routed input selects
  // ----------------------------------------------------------------

  // Drive per effective function, direction bit only in GPIO
  always_comb begin
    drive_oe = '0;
    drive_val = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (slot[i][SLOT_IDX_GPIO]) begin
        drive_oe[i] = port_b_direction_register[i];
        drive_val[i] = gpio_out[i];
      end else if (slot[i][SLOT_IDX_ALT2] && ALT2_DRIVE[i]) begin
        drive_oe[i] = 1'b1;
        drive_val[i] = alt2_val[i];
      end else if (slot[i][SLOT_IDX_ALT3] && ALT3_DRIVE[i]) begin
        drive_oe[i] = 1'b1;
        drive_val[i] = alt3_val[i];
      end
    end
  end

  // Interrupt inputs take code 1 on pins 2-9
  for (genvar j = 0; j < IRQ_COUNT; j++) begin : g_irq
    assign irq_sel[j] = slot[j+IRQ_FIRST_PIN][SLOT_IDX_ALT1];
  end

  // Output enable inputs take code 2 on pins 2-5
  for (genvar k = 0; k < POE_COUNT; k++) begin : g_poe
    assign poe_sel[k] = slot[k+POE_FIRST_PIN][SLOT_IDX_ALT2];
  end

  // Code 3 inputs on pins 9, 8 and 7
  assign adc_sel = slot[ADC_PIN][SLOT_IDX_ALT3];
  assign wait_sel = slot[WAIT_PIN][SLOT_IDX_ALT3];
  assign bus_request_in_n_sel = slot[BUS_REQUEST_IN_N_PIN][SLOT_IDX_ALT3];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Word selects, shared by the read mux and the write path
  assign hit_upper = reg_hit(avs_address, UPPER_OFFSET);
  assign hit_lower = reg_hit(avs_address, LOWER_OFFSET);
  assign hit_level = reg_hit(avs_address, LEVEL_OFFSET);

  // Writes land on the edge where waitrequest is low
  assign write_land = avs_write & state_q.ack;

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------

  // Stored codes read back as written, overrides not reflected
  always_comb begin
    read_mux = '0;
    if (hit_upper) begin
      read_mux[REG_W-1:0] = state_q.upper;
    end else if (hit_lower) begin
      read_mux[REG_W-1:0] = state_q.lower;
    end else if (hit_level) begin
      read_mux[PIN_COUNT-1:0] = state_q.pin_sync;
      read_mux[LEVEL_SC_BIT] = single_chip_mode;
      read_mux[LEVEL_ROM_BIT] = rom_invalid_mode;
    end
  end

  // One wait state on every access
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~state_q.ack;
  assign avs_readdata = state_q.rdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  always_comb begin
    state_d = state_q;

    // Pin synchroniser
    state_d.pin_meta = pin_in;
    state_d.pin_sync = state_q.pin_meta;

    // Bus handshake and read capture
    state_d.ack = req & ~state_q.ack;
    if (req && !state_q.ack) begin
      state_d.rdata = read_mux;
    end

    // Register update with byte lanes
    if (write_land) begin
      if (hit_upper) begin
        state_d.upper = merge_write(state_q.upper,
                                    avs_writedata[REG_W-1:0],
                                    avs_byteenable, UPPER_WMASK);
      end else if (hit_lower) begin
        state_d.lower = merge_write(state_q.lower,
                                    avs_writedata[REG_W-1:0],
                                    avs_byteenable, LOWER_WMASK);
      end
    end

    // Pin drive per effective function
    state_d.pin_oe = drive_oe;
    state_d.pin_out = drive_val;

    // Pin levels to the port data path
    state_d.gpio_in = state_q.pin_sync;

    // Interrupt request inputs on code 1, pins 2-9
    state_d.irq = irq_sel &
                  state_q.pin_sync[PIN_COUNT-1:IRQ_FIRST_PIN];

    // Port output enable inputs on code 2, pins 2-5
    state_d.poe = poe_sel &
                  state_q.pin_sync[POE_FIRST_PIN+POE_COUNT-1:POE_FIRST_PIN];

    // Inputs on code 3 for pins 9, 8 and 7
    state_d.adc = adc_sel & state_q.pin_sync[ADC_PIN];
    state_d.wait_in = wait_sel & state_q.pin_sync[WAIT_PIN];
    state_d.bus_request_in_n_n = ~(bus_request_in_n_sel & ~state_q.pin_sync[BUS_REQUEST_IN_N_PIN]);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Only the power-on reset reaches this block
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // All data outputs straight from flip-flops
  assign pin_out = state_q.pin_out;
  assign pin_oe = state_q.pin_oe;
  assign gpio_in = state_q.gpio_in;
  assign interrupt_request_in = state_q.irq;
  assign output_enable_in = state_q.poe;
  assign adc_trigger_in = state_q.adc;
  assign bus_wait_in = state_q.wait_in;
  assign bus_request_in_n = state_q.bus_request_in_n_n;

endmodule : port_b_pin_function_select

// file: verification/pin_select_checker.sv
// Port-level assertions for the port B pin function select block
`timescale 1ns/100ps
module pin_select_checker
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [AVS_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Mode, pads and routed signals
  input wire logic single_chip_mode,
  input wire logic rom_invalid_mode,
  input wire logic [PIN_COUNT-1:0] pin_in,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] port_b_direction_register,
  input wire logic [PIN_COUNT-1:0] gpio_out,
  input wire logic [PIN_COUNT-1:0] gpio_in,
  input wire logic [IRQ_COUNT-1:0] interrupt_request_in,
  input wire logic [POE_COUNT-1:0] output_enable_in,
  input wire logic adc_trigger_in,
  input wire logic address_bit_17,
  input wire logic address_bit_16,
  input wire logic bus_wait_in,
  input wire logic bus_request_in_n
);
  // ----------
  // Helpers
  // ----------
  logic [1:0] settle_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Edges since reset, saturating at three
  always_ff @(posedge clk) begin
    if (sys_rst) settle_q <= 2'h0;
    else if (settle_q != 2'h3) settle_q <= settle_q + 2'h1;
  end

  // Pad levels unchanged over three edges
  sequence held3;
    $stable(pin_in)[*3];
  endsequence

  // ----------
  // Assertions
  // ----------
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state is not one cycle");
  upper_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address[3:2] == 2'h0
    |-> avs_readdata[15:4] == 12'h000) else $error("upper reserved set");
  lower_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address[3:2] == 2'h1
    |-> !avs_readdata[3] && !avs_readdata[1]) else $error("lower reserved");
  reset_clear_a: assert property (
    $fell(sys_rst) |-> pin_oe == 10'h000 && pin_out == 10'h000
    && bus_request_in_n) else $error("outputs not cleared by reset");
  chip_gpio_a: assert property (
    single_chip_mode |=> pin_oe[1:0] == $past(port_b_direction_register[1:0])
    && pin_out[1:0] == $past(gpio_out[1:0])) else $error("pins 1:0 not io");
  rom_addr_a: assert property (
    rom_invalid_mode && !single_chip_mode |=> pin_oe[1:0] == 2'h3
    && pin_out[1:0] == {$past(address_bit_17), $past(address_bit_16)})
    else $error("pins 1:0 not address");
  chip_bus_a: assert property (
    single_chip_mode |=> !bus_wait_in && bus_request_in_n)
    else $error("bus inputs active in single chip");
  routed_level_a: assert property (
    (interrupt_request_in & ~gpio_in[9:2]) == 8'h00
    && (output_enable_in & (~gpio_in[5:2] | interrupt_request_in[3:0]))
    == 4'h0 && (!adc_trigger_in || gpio_in[9])) else $error("bad routing");
  sync_path_a: assert property (
    ((settle_q == 2'h3) and held3) |-> gpio_in == pin_in)
    else $error("pad level not seen");
endmodule : pin_select_checker

bind port_b_pin_function_select pin_select_checker chk (
  .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .single_chip_mode, .rom_invalid_mode, .pin_in,
  .pin_out, .pin_oe, .port_b_direction_register, .gpio_out, .gpio_in,
  .interrupt_request_in, .output_enable_in, .adc_trigger_in,
  .address_bit_17, .address_bit_16, .bus_wait_in, .bus_request_in_n);

// file: verification/pin_side_model.sv
// Board-side pad model: resolves each pad from block drive and board
`timescale 1ns/100ps
module pin_side_model
  import pin_mux_pkg::*;
(
  // Block side of the pads
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  // Level the board puts on undriven pads
  input wire logic [PIN_COUNT-1:0] board_level,
  // Resolved pad level
  output logic [PIN_COUNT-1:0] pin_in
);
  // Block drive wins where enabled
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule : pin_side_model

// file: verification/port_b_pin_function_select_test.sv
// Self-checking bench for the port B pin function select block
`timescale 1ns/100ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module port_b_pin_function_select_test
  import pin_mux_pkg::*;
  ;
  // ----------
  // Signals
  // ----------
  logic clk = 1'b0, sys_rst = 1'b1, sc = 1'b0, ri = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h3;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [9:0] pin_in, pin_out, pin_oe, gio, board = 10'h36D;
  logic [9:0] dir = 10'h2B5, gout = 10'h1CA;
  logic [7:0] irq;
  logic [3:0] poe;
  logic [5:0] ab = 6'h2D;
  logic [4:0] sb = 5'h15;
  logic adc, wt, brq;
  int num_errors = 0, samples_checked = 0;

  // Clock
  initial begin
    forever #2 clk = ~clk;
  end

  port_b_pin_function_select DUT (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .single_chip_mode(sc), .rom_invalid_mode(ri), .pin_in, .pin_out,
    .pin_oe, .port_b_direction_register(dir), .gpio_out(gout),
    .gpio_in(gio), .interrupt_request_in(irq), .output_enable_in(poe),
    .adc_trigger_in(adc), .address_bit_21(ab[5]), .address_bit_20(ab[4]),
    .address_bit_19(ab[3]), .address_bit_18(ab[2]), .address_bit_17(ab[1]),
    .address_bit_16(ab[0]), .read_write_direction_out(sb[3]),
    .upper_column_strobe(sb[2]), .lower_column_strobe(sb[1]),
    .row_address_strobe(sb[0]), .bus_grant_out(sb[4]), .bus_wait_in(wt),
    .bus_request_in_n(brq));
  pin_side_model pads (.pin_out, .pin_oe, .board_level(board), .pin_in);

  // ----------
  // Tasks
  // ----------
  // Avalon transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0000, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : xfer

  // Reset values, reserved bits, lanes, unmapped place, clearing by reset
  task automatic t_regs();
    xfer(1'b0, LOWER_OFFSET, 16'h0);
    `CHK(rd[15:0], 16'h0000)
    xfer(1'b1, UPPER_OFFSET, 16'hFFFF);
    xfer(1'b0, UPPER_OFFSET, 16'h0);
    `CHK(rd[15:0], 16'h000F)
    xfer(1'b1, LOWER_OFFSET, 16'hFFFF);
    xfer(1'b0, LOWER_OFFSET, 16'h0);
    `CHK(rd[15:0], 16'hFFF5)
    avs_byteenable <= 4'h1;
    xfer(1'b1, LOWER_OFFSET, 16'h0);
    avs_byteenable <= 4'h3;
    xfer(1'b1, 4'hC, 16'hFFFF);
    xfer(1'b0, LOWER_OFFSET, 16'h0);
    `CHK(rd[15:0], 16'hFF00)
    xfer(1'b0, 4'hC, 16'h0);
    `CHK(rd[15:0], 16'h0000)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, UPPER_OFFSET, 16'h0);
    `CHK(rd[15:0], 16'h0000)
    $display("t_regs done");
  endtask : t_regs

  // Every code on every pin under each operating mode
  task automatic t_pins();
    logic [1:0] c;
    logic s, r;
    logic [9:0] eo, ev;
    logic [15:0] lo;
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        c = k[1:0];
        s = (m == 1);
        r = (m == 2);
        sc <= s;
        ri <= r;
        lo = {c, c, c, c, c, c, 1'b0, c[0], 1'b0, c[0]};
        xfer(1'b1, UPPER_OFFSET, {12'h000, c, c});
        xfer(1'b1, LOWER_OFFSET, lo);
        repeat (6) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
          eo[i] = dir[i];
          ev[i] = gout[i];
          if (i < 2) begin
            if (c[0] ? !s : r) {eo[i], ev[i]} = {1'b1, ab[i]};
          end else if (c == 2'h1 || (c == 2'h2 && i < 6)) eo[i] = 1'b0;
          else if (c == 2'h2 && !s) {eo[i], ev[i]} = {1'b1, ab[i-4]};
          else if (c == 2'h3 && (i == 9 || (i > 6 && !s))) eo[i] = 1'b0;
          else if (c == 2'h3 && i < 7 && (i == 5 || !s))
            {eo[i], ev[i]} = {1'b1, sb[i-2]};
        end
        `CHK(pin_oe, eo)
        `CHK(pin_out & eo, ev & eo)
        `CHK(gio, (eo & ev) | (~eo & board))
        `CHK(irq, c == 2'h1 ? board[9:2] : 8'h00)
        `CHK(poe, c == 2'h2 ? board[5:2] : 4'h0)
        `CHK({adc, wt}, {c == 2'h3 && board[9], c == 2'h3 && !s && board[8]})
        `CHK(brq, c == 2'h3 && !s ? board[7] : 1'b1)
        xfer(1'b0, LOWER_OFFSET, 16'h0);
        `CHK(rd[15:0], lo)
        xfer(1'b0, UPPER_OFFSET, 16'h0);
        `CHK(rd[15:0], {12'h000, c, c})
        xfer(1'b0, LEVEL_OFFSET, 16'h0);
        `CHK(rd[17:0], {r, s, 6'h00, (eo & ev) | (~eo & board)})
      end
    end
    $display("t_pins done");
  endtask : t_pins

  // Verdict and end of run
  task automatic finish_test();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_pins();
    finish_test();
  end

  // Watchdog
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : port_b_pin_function_select_test
